// File: hw/cycle_timer.sv
// Machine-cycle timer producing time states T0 to T7.
`timescale 1ns/1ps
module cycle_timer (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // Time states
   timing_if.gen tim
);
   import fpla_pkg::*;

   time_state_t state;
   time_state_t next_state;
   logic [1:0] cnt;
   logic [1:0] next_cnt;

   always_comb begin
      next_cnt = (cnt == STATE_CNT_LAST) ? STATE_CNT_RST : 2'(cnt + 2'h1);
      next_state = state;
      if (cnt == STATE_CNT_LAST) begin
         unique case (state)
            T0: next_state = T1;
            T1: next_state = T2;
            T2: next_state = T3;
            T3: next_state = T4;
            T4: next_state = T5;
            T5: next_state = T6;
            T6: next_state = T7;
            T7: next_state = T0;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= T0;
         cnt <= STATE_CNT_RST;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // The strobe is one clock wide, at the first clock of T2 and of T5.
   assign tim.state = state;
   assign tim.in_t2 = (state == T2);
   assign tim.strobe = ((state == T2) || (state == T5)) && (cnt == STATE_CNT_RST);
   assign tim.end_of_cycle_time = (state == T7) && (cnt == STATE_CNT_LAST);
endmodule : cycle_timer

// File: hw/front_panel_load_address.sv
// Front-panel load-address control with its registers on classic Wishbone.
//
// Operation
// - A press of the switch is taken only while the processor is halted.
// - A latch holds the request from press until the switch is released.
// - The switch enable follows the request with no wait for a time state.
// - The switch enable drives the switch register onto the input bus.
// - At T2 the switch enable gates the input bus onto the first operand bus.
// - At T2 an active-low gate merges both operand buses, the second held at zero.
// - At T2 with the request true the memory-address select is raised.
// - The memory-address select yields strobes for all address bits at T2 and T5.
// - At T2 the request also raises the program-counter select.
// - The program-counter select yields strobes for all counter bits at T2 and T5.
// - The request holds both run-state flip-flops reset.
// - The request sets phase one at the end of the first machine cycle after the press.
// - Each address and counter bit holding one lights its lamp.
// - While held, the memory-address select is one 200 ns pulse per 1.6 us cycle.
// - The switch enable is low while a press taken when halted is held and high after release.
`timescale 1ns/1ps
module front_panel_load_address #(
   parameter int DATA_W = fpla_pkg::WORD_W
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Panel switch contacts and switch register
   input wire logic press_contact_i,
   input wire logic release_contact_i,
   input wire logic [DATA_W-1:0] switch_reg_i,
   // Control toward the datapath
   output logic switch_enable_out_n_o,
   output logic switch_reg_read_enable_o,
   output logic input_bus_gate_o,
   output logic early_result_gate_n_o,
   output logic switch_to_maddr_select_o,
   output logic switch_to_pc_select_o,
   output logic [DATA_W-1:0] maddr_bit_strobes_o,
   output logic [DATA_W-1:0] pc_bit_strobes_o,
   output logic [DATA_W-1:0] io_input_bus_o,
   // Indicators
   output logic [DATA_W-1:0] maddr_lamps_o,
   output logic [DATA_W-1:0] pc_lamps_o,
   output logic run_lamp_o,
   output logic phase_one_o
);
   import fpla_pkg::*;

   if (DATA_W < 1 || DATA_W > 32) begin : g_width_check
      $error("DATA_W must lie between 1 and 32.");
   end

   timing_if tim ();

   cycle_timer u_timer (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .tim(tim)
   );

   // Contacts come from the panel, so both pass two flip-flops first.
   logic [1:0] press_sync;
   logic [1:0] release_sync;
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         press_sync <= 2'h0;
         release_sync <= 2'h0;
      end else begin
         press_sync <= {press_sync[0], press_contact_i};
         release_sync <= {release_sync[0], release_contact_i};
      end
   end
   logic press_s;
   logic release_s;
   assign press_s = press_sync[1];
   assign release_s = release_sync[1];

   // The switch register is a bank of panel switches, so it passes two flip-flops as well.
   // A word changed while it is sampled may tear for a clock; the operator holds it still during a load.
   logic [DATA_W-1:0] switch_sync_a;
   logic [DATA_W-1:0] switch_sync_b;
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         switch_sync_a <= WORD_RST;
         switch_sync_b <= WORD_RST;
      end else begin
         switch_sync_a <= switch_reg_i;
         switch_sync_b <= switch_sync_a;
      end
   end

   // Control state.
   logic load_address_request;
   logic run_state_one;
   logic run_state_two;
   logic phase_one_state;
   logic phase_seen;
   logic [DATA_W-1:0] maddr;
   logic [DATA_W-1:0] pc;
   logic [DATA_W-1:0] result_hold;
   logic hold_valid;
   logic next_load_address_request;
   logic next_run_state_one;
   logic next_run_state_two;
   logic next_phase_one_state;
   logic next_phase_seen;
   logic [DATA_W-1:0] next_maddr;
   logic [DATA_W-1:0] next_pc;
   logic [DATA_W-1:0] next_result_hold;
   logic next_hold_valid;

   // Datapath terms of the current clock.
   logic swen;
   logic sel_maddr;
   logic sel_pc;
   logic in_gate;
   logic result_gate_n;
   logic load_strobe;
   logic [DATA_W-1:0] io_bus;
   logic [DATA_W-1:0] operand_a;
   logic [DATA_W-1:0] operand_b;
   logic [DATA_W-1:0] result_bus;
   logic [DATA_W-1:0] load_value;

   // Bus decode.
   logic wb_req;
   logic wr_ctrl;
   logic run_cmd;
   logic ph1_clr;
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_ctrl = wb_req && wb_we_i && (wb_adr_i == CTRL_OFS) && wb_sel_i[0];
   assign run_cmd = wr_ctrl && wb_dat_i[CTRL_RUN_BIT];
   assign ph1_clr = wr_ctrl && wb_dat_i[CTRL_PH1_CLR_BIT];

   always_comb begin
      swen = load_address_request;
      io_bus = swen ? switch_sync_b : WORD_RST;
      in_gate = swen && tim.in_t2;
      operand_a = in_gate ? io_bus : WORD_RST;
      operand_b = WORD_RST;
      result_gate_n = !(swen && tim.in_t2);
      result_bus = !result_gate_n ? (operand_a | operand_b) : WORD_RST;
      sel_maddr = load_address_request && tim.in_t2;
      sel_pc = load_address_request && tim.in_t2;
      // T5 has no result on the bus, so its strobe reloads the value held at T2.
      // A request that starts after T2 skips that T5, since nothing of its own is held yet.
      load_strobe = load_address_request && tim.strobe && (tim.in_t2 || hold_valid);
      load_value = tim.in_t2 ? result_bus : result_hold;
   end

   always_comb begin
      next_load_address_request = load_address_request;
      if (release_s) begin
         next_load_address_request = 1'b0;
      end else if (press_s && !run_state_two) begin
         next_load_address_request = 1'b1;
      end
      next_run_state_one = run_state_one || run_cmd;
      next_run_state_two = run_state_two || (run_state_one && tim.end_of_cycle_time);
      if (load_address_request) begin
         next_run_state_one = 1'b0;
         next_run_state_two = 1'b0;
      end
      next_phase_seen = load_address_request && (phase_seen || tim.end_of_cycle_time);
      next_phase_one_state = phase_one_state && !ph1_clr;
      if (load_address_request && tim.end_of_cycle_time && !phase_seen) begin
         next_phase_one_state = 1'b1;
      end
      next_result_hold = result_hold;
      if (!result_gate_n) begin
         next_result_hold = result_bus;
      end
      next_hold_valid = load_address_request && (hold_valid || !result_gate_n);
      next_maddr = maddr;
      next_pc = pc;
      if (load_strobe) begin
         next_maddr = load_value;
         next_pc = load_value;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         load_address_request <= 1'b0;
         run_state_one <= 1'b0;
         run_state_two <= 1'b0;
         phase_one_state <= 1'b0;
         phase_seen <= 1'b0;
         result_hold <= WORD_RST;
         hold_valid <= 1'b0;
         maddr <= WORD_RST;
         pc <= WORD_RST;
      end else begin
         load_address_request <= next_load_address_request;
         run_state_one <= next_run_state_one;
         run_state_two <= next_run_state_two;
         phase_one_state <= next_phase_one_state;
         phase_seen <= next_phase_seen;
         result_hold <= next_result_hold;
         hold_valid <= next_hold_valid;
         maddr <= next_maddr;
         pc <= next_pc;
      end
   end

   // Registered outputs; datapath outputs lag their terms by one clock, lamp, run and phase outputs do not.
   logic next_seo_n;
   logic next_rd_en;
   logic next_in_gate;
   logic next_res_gate_n;
   logic next_sel_m;
   logic next_sel_p;
   logic [DATA_W-1:0] next_mstb;
   logic [DATA_W-1:0] next_pstb;
   logic [DATA_W-1:0] next_io_bus;

   always_comb begin
      next_seo_n = !swen;
      next_rd_en = swen;
      next_in_gate = in_gate;
      next_res_gate_n = result_gate_n;
      next_sel_m = sel_maddr;
      next_sel_p = sel_pc;
      next_io_bus = io_bus;
   end

   for (genvar b = 0; b < DATA_W; b++) begin : g_strobe
      assign next_mstb[b] = load_strobe;
      assign next_pstb[b] = load_strobe;
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         switch_enable_out_n_o <= 1'b1;
         switch_reg_read_enable_o <= 1'b0;
         input_bus_gate_o <= 1'b0;
         early_result_gate_n_o <= 1'b1;
         switch_to_maddr_select_o <= 1'b0;
         switch_to_pc_select_o <= 1'b0;
         maddr_bit_strobes_o <= WORD_RST;
         pc_bit_strobes_o <= WORD_RST;
         io_input_bus_o <= WORD_RST;
         maddr_lamps_o <= WORD_RST;
         pc_lamps_o <= WORD_RST;
         run_lamp_o <= 1'b0;
         phase_one_o <= 1'b0;
      end else begin
         switch_enable_out_n_o <= next_seo_n;
         switch_reg_read_enable_o <= next_rd_en;
         input_bus_gate_o <= next_in_gate;
         early_result_gate_n_o <= next_res_gate_n;
         switch_to_maddr_select_o <= next_sel_m;
         switch_to_pc_select_o <= next_sel_p;
         maddr_bit_strobes_o <= next_mstb;
         pc_bit_strobes_o <= next_pstb;
         io_input_bus_o <= next_io_bus;
         maddr_lamps_o <= next_maddr;
         pc_lamps_o <= next_pc;
         run_lamp_o <= next_run_state_two;
         phase_one_o <= next_phase_one_state;
      end
   end

   // Wishbone slave: ack one clock after the request, then dropped for one clock.
   logic next_ack;
   logic [31:0] next_dat;
   logic [31:0] status_word;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[STAT_REQ_BIT] = load_address_request;
      status_word[STAT_RUN1_BIT] = run_state_one;
      status_word[STAT_RUN2_BIT] = run_state_two;
      status_word[STAT_PH1_BIT] = phase_one_state;
      status_word[STAT_TS_LSB +: 3] = tim.state;
      next_ack = wb_req;
      next_dat = 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
         unique case (wb_adr_i)
            STATUS_OFS: next_dat = status_word;
            MADDR_OFS: next_dat = 32'(maddr);
            PC_OFS: next_dat = 32'(pc);
            default: next_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end
endmodule : front_panel_load_address

// File: shared/fpla_pkg.sv
// Constants, types and register map of the front-panel load-address block.
package fpla_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int TIME_STATE_NS = 200;
   localparam int MACHINE_CYCLE_NS = 1600;
   localparam int STATE_CLKS = (TIME_STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STATES_PER_CYCLE = MACHINE_CYCLE_NS / TIME_STATE_NS;
   localparam int WORD_W = 16;
   localparam logic [1:0] STATE_CNT_RST = 2'h0;
   localparam logic [1:0] STATE_CNT_LAST = 2'(STATE_CLKS - 1);
   // Wishbone byte offsets.
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] MADDR_OFS = 4'h8;
   localparam logic [3:0] PC_OFS = 4'hC;
   // Control register fields.
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_PH1_CLR_BIT = 1;
   // Status register fields.
   localparam int STAT_REQ_BIT = 0;
   localparam int STAT_RUN1_BIT = 1;
   localparam int STAT_RUN2_BIT = 2;
   localparam int STAT_PH1_BIT = 3;
   localparam int STAT_TS_LSB = 4;
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   typedef enum logic [2:0] {
      T0 = 3'h0, T1 = 3'h1, T2 = 3'h3, T3 = 3'h2,
      T4 = 3'h6, T5 = 3'h7, T6 = 3'h5, T7 = 3'h4
   } time_state_t;
endpackage : fpla_pkg

// File: shared/timing_if.sv
// Time-state signals from the cycle timer to the load-address logic.
`timescale 1ns/1ps
interface timing_if;
   import fpla_pkg::*;
   time_state_t state;
   logic in_t2;
   logic strobe;
   logic end_of_cycle_time;
   modport gen (output state, output in_t2, output strobe, output end_of_cycle_time);
   modport use_side (input state, input in_t2, input strobe, input end_of_cycle_time);
endinterface : timing_if

// File: testbench/fpla_properties.sv
// Port checks for the load-address control.
`timescale 1ns/1ps
module fpla_properties #(
   parameter int DATA_W = 16
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // Observed ports
   input wire logic [DATA_W-1:0] switch_reg_i,
   input wire logic switch_enable_out_n_o,
   input wire logic switch_reg_read_enable_o,
   input wire logic input_bus_gate_o,
   input wire logic early_result_gate_n_o,
   input wire logic switch_to_maddr_select_o,
   input wire logic switch_to_pc_select_o,
   input wire logic [DATA_W-1:0] maddr_bit_strobes_o,
   input wire logic [DATA_W-1:0] pc_bit_strobes_o,
   input wire logic [DATA_W-1:0] io_input_bus_o,
   input wire logic [DATA_W-1:0] maddr_lamps_o,
   input wire logic [DATA_W-1:0] pc_lamps_o,
   input wire logic run_lamp_o,
   input wire logic phase_one_o
);
   logic sel_q;
   logic seen;
   logic [7:0] gap;
   // The gap counter spans a whole machine cycle, too long for a repetition.
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sel_q <= 1'b0;
         seen <= 1'b0;
         gap <= 8'h00;
      end else begin
         sel_q <= switch_to_maddr_select_o;
         seen <= switch_reg_read_enable_o & (seen | (switch_to_maddr_select_o & ~sel_q));
         gap <= (switch_to_maddr_select_o & ~sel_q) ? 8'h00 : gap + 8'h01;
      end
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);
   sequence strobe_all;
      maddr_bit_strobes_o == '1 && pc_bit_strobes_o == '1;
   endsequence
   sequence strobe_none;
      maddr_bit_strobes_o == '0 && pc_bit_strobes_o == '0;
   endsequence
   strobe_pair_a: assert property ($rose(switch_to_maddr_select_o) |-> strobe_all ##1 strobe_none[*8]
      ##1 strobe_none[*3] ##1 strobe_all) else $error("strobe timing wrong");
   sel_period_a: assert property ($rose(switch_to_maddr_select_o) && seen |-> gap == 8'h1F)
      else $error("select period wrong");
   sel_width_a: assert property ($rose(switch_to_maddr_select_o) |-> switch_to_maddr_select_o[*4]
      ##1 !switch_to_maddr_select_o) else $error("select width wrong");
   pc_select_a: assert property (switch_to_pc_select_o == switch_to_maddr_select_o) else $error("pc select");
   input_gate_a: assert property (input_bus_gate_o == switch_to_maddr_select_o) else $error("input gate");
   result_gate_a: assert property (early_result_gate_n_o == !input_bus_gate_o) else $error("result gate");
   enable_pair_a: assert property (switch_enable_out_n_o == !switch_reg_read_enable_o) else $error("enable");
   // Three clocks back: two synchroniser stages and the output register.
   bus_value_a: assert property (switch_reg_read_enable_o |-> io_input_bus_o == $past(switch_reg_i, 3))
      else $error("input bus value");
   run_held_a: assert property (switch_reg_read_enable_o |-> !run_lamp_o) else $error("run not held");
   phase_set_a: assert property ($rose(switch_reg_read_enable_o) |-> ##[0:34] phase_one_o)
      else $error("phase one late");
   lamp_match_a: assert property (pc_bit_strobes_o[0] |-> maddr_lamps_o == io_input_bus_o
      && pc_lamps_o == io_input_bus_o) else $error("lamps");
   reset_state_a: assert property (!$past(rstn_i) |-> switch_enable_out_n_o && !phase_one_o && !run_lamp_o)
      else $error("reset state");
endmodule : fpla_properties

bind front_panel_load_address fpla_properties #(.DATA_W(DATA_W)) u_props (.clock_i, .rstn_i, .switch_reg_i,
   .switch_enable_out_n_o, .switch_reg_read_enable_o, .input_bus_gate_o, .early_result_gate_n_o,
   .switch_to_maddr_select_o, .switch_to_pc_select_o, .maddr_bit_strobes_o, .pc_bit_strobes_o,
   .io_input_bus_o, .maddr_lamps_o, .pc_lamps_o, .run_lamp_o, .phase_one_o);

// File: testbench/front_panel_load_address_tb.sv
// Self-checking bench for the load-address control.
`timescale 1ns/1ps
module front_panel_load_address_tb;
   import fpla_pkg::*;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic hold = 1'b0;
   logic [15:0] value = 16'h0000;
   logic [31:0] dat_o;
   logic ack, press, rel, seo_n, rre, erg_n, run, ph1;
   logic [15:0] sw, mstb, iob, mlamp, plamp;
   int miscompares = 0;
   int check_count = 0;
   panel_model panel (.clock_i(clock_i), .hold_i(hold), .value_i(value), .press_contact_o(press),
      .release_contact_o(rel), .switch_reg_o(sw));
   front_panel_load_address uut (.clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .press_contact_i(press), .release_contact_i(rel), .switch_reg_i(sw), .switch_enable_out_n_o(seo_n),
      .switch_reg_read_enable_o(rre), .input_bus_gate_o(), .early_result_gate_n_o(erg_n),
      .switch_to_maddr_select_o(), .switch_to_pc_select_o(), .maddr_bit_strobes_o(mstb),
      .pc_bit_strobes_o(), .io_input_bus_o(iob), .maddr_lamps_o(mlamp), .pc_lamps_o(plamp),
      .run_lamp_o(run), .phase_one_o(ph1));
   initial forever #25 clock_i = ~clock_i;
   task automatic tick(input int k);
      repeat (k) @(posedge clock_i);
   endtask : tick
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Classic cycle: the request stands until ack is seen at an edge.
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clock_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      chk(ack, 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task automatic reset_bus;
      chk(seo_n, 1'b1);
      chk(erg_n, 1'b1);
      wb(1'b1, STATUS_OFS, 32'h0000000F);
      wb(1'b0, STATUS_OFS, 32'h0);
      chk(rdat & 32'hF, 32'h0);
      wb(1'b1, 4'h2, 32'hFFFFFFFF);
      wb(1'b0, 4'h2, 32'h0);
      chk(rdat, 32'h0);
   endtask : reset_bus
   task automatic load(input logic [15:0] v);
      int n;
      n = 0;
      hold <= 1'b1;
      value <= v;
      while (seo_n !== 1'b0 && n < 10) begin
         @(posedge clock_i);
         n++;
      end
      chk(n < 10, 1'b1);
      chk(iob, v);
      n = 0;
      while (mstb[0] !== 1'b1 && n < 80) begin
         @(posedge clock_i);
         n++;
      end
      chk(n < 80, 1'b1);
      tick(2);
      chk(mlamp, v);
      chk(plamp, v);
      wb(1'b0, MADDR_OFS, 32'h0);
      chk(rdat, {16'h0000, v});
      wb(1'b0, PC_OFS, 32'h0);
      chk(rdat, {16'h0000, v});
      wb(1'b1, CTRL_OFS, 32'h1);
      tick(40);
      chk(run, 1'b0);
      wb(1'b0, STATUS_OFS, 32'h0);
      chk(rdat & 32'hF, 32'h9);
      chk(ph1, 1'b1);
      hold <= 1'b0;
      tick(6);
      chk(seo_n, 1'b1);
      chk(rre, 1'b0);
      wb(1'b0, STATUS_OFS, 32'h0);
      chk(rdat & 32'h7, 32'h0);
   endtask : load
   task automatic run_block;
      wb(1'b1, CTRL_OFS, 32'h1);
      tick(40);
      chk(run, 1'b1);
      hold <= 1'b1;
      value <= 16'hFFFF;
      tick(40);
      chk(seo_n, 1'b1);
      wb(1'b0, MADDR_OFS, 32'h0);
      chk(rdat, 32'h00005A3C);
      hold <= 1'b0;
   endtask : run_block
   task automatic end_sim;
      $display("check_count=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   // The whole sequence needs well under a thousand cycles.
   initial begin
      tick(4000);
      miscompares++;
      end_sim;
   end
   initial begin
      tick(20);
      rstn_i <= 1'b1;
      tick(2);
      reset_bus;
      load(16'hA5C3);
      wb(1'b1, CTRL_OFS, 32'h2);
      load(16'h5A3C);
      run_block;
      end_sim;
   end
endmodule : front_panel_load_address_tb

// File: testbench/panel_model.sv
// Operator panel model with a momentary switch and a switch register.
`timescale 1ns/1ps
module panel_model (
   // Clock
   input wire logic clock_i,
   // Operator commands
   input wire logic hold_i,
   input wire logic [15:0] value_i,
   // Panel contacts and switch register
   output logic press_contact_o,
   output logic release_contact_o,
   output logic [15:0] switch_reg_o
);
   // Both contacts change on one edge; bounce is left for the device latch to absorb.
   always_ff @(posedge clock_i) begin
      press_contact_o <= hold_i;
      release_contact_o <= ~hold_i;
      switch_reg_o <= value_i;
   end
endmodule : panel_model
